/* File: common/scr_pkg.sv */
package scr_pkg;
  // Reset configuration word low, field positions
  localparam int          RCW_W         = 32;
  localparam int          FACTOR_LSB      = 24;
  localparam int          FACTOR_W        = 4;
  localparam int          CORE_LSB        = 16;
  localparam int          CORE_W          = 7;
  localparam int          MEM_MODE_BIT    = 30;
  localparam int          LB_MODE_BIT     = 31;
  // System PLL factor encodings
  localparam logic [3:0]  FACTOR_X16_CODE = 4'h0;
  localparam logic [3:0]  FACTOR_RSVD     = 4'h1;
  localparam logic [5:0]  FACTOR_X16      = 6'h10;
  // Register byte offsets
  localparam logic [3:0]  LBCC_OFS      = 4'h0;
  localparam logic [3:0]  UCLK_OFS      = 4'h4;
  localparam logic [3:0]  CFGW_OFS      = 4'h8;
  localparam logic [3:0]  RATIO_OFS     = 4'hC;
  // Local bus divider select codes
  localparam logic [3:0]  LBDIV_2       = 4'h2;
  localparam logic [3:0]  LBDIV_4       = 4'h4;
  localparam logic [3:0]  LBDIV_8       = 4'h8;
  localparam logic [3:0]  LBDIV_RST     = 4'h2;
  // Per-unit clock selection
  localparam int          N_UNITS       = 4;
  localparam logic [1:0]  UCLK_OFF      = 2'h0;
  localparam logic [1:0]  UCLK_FULL     = 2'h1;
  localparam logic [1:0]  UCLK_HALF     = 2'h2;
  localparam logic [1:0]  UCLK_THIRD    = 2'h3;
  localparam logic [7:0]  UCLK_RST      = 8'hFF;
  localparam logic        PCI_RST       = 1'b1;
  localparam int          PCI_BIT       = 8;
  // Cycles for straps to cross the synchroniser before capture
  localparam logic [1:0]  CAP_WAIT      = 2'h2;
  // Strap vector: {txd3, pci host, input divide, reset_config_word_low}
  localparam int          STRAP_W       = RCW_W + 3;
endpackage

/* File: src/scr_clock_ratio_ctrl.sv */
// The Avalon-MM register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// RULE1: csb ratio is system PLL factor times one plus input divide bit.
// RULE2: In PCI host mode the prescaled input term is the primary clock input.
// RULE3: Core ratio from core PLL field, applied to the system bus clock.
// RULE4: PLL factor and core ratio come from captured reset config word low.
// RULE5: Memory-controller clock is csb times one plus memory clock-mode bit.
// RULE6: Memory bus clock out is memory-controller clock divided by two.
// RULE7: Local sync and three local clock outputs come from the local divider.
// RULE8: Local bus divides internal clock by 2/4/8; internal is 1x or 2x csb.
// RULE9: Software sets per-unit clocks; four units default third, PCI full.
// RULE10: Memory clock enables and gigabit tx clock are driven during reset.
// RULE11: Board holds ethernet tx data bit 3 high during hard reset.
// RULE12: Factor code 0000 means sixteen, 0001 reserved, others binary value.
// RULE13: Captured ratios stay constant until next reset; all clocks use them. Here the gigabit tx clock toggles every sys_clk without them.
module scr_clock_ratio_ctrl (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic [scr_pkg::RCW_W-1:0]   reset_config_word_low,
  input  wire logic                        input_divide_config_bit,
  input  wire logic                        pci_host_mode,
  input  wire logic                        ethernet1_tx_data_bit3,
  input  wire logic [3:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  output logic [31:0]                      avs_readdata,
  output logic                             avs_waitrequest,
  output logic                             config_valid,
  output logic                             config_reserved,
  output logic [5:0]                       csb_input_ratio,
  output logic [5:0]                       csb_primary_ratio,
  output logic [scr_pkg::CORE_W-1:0]       core_pll_ratio,
  output logic                             memory_bus_clock_out_p,
  output logic                             memory_bus_clock_out_n,
  output logic                             memory_data_tick,
  output logic                             local_sync_clock_out,
  output logic [2:0]                       local_bus_clock_outputs,
  output logic [scr_pkg::N_UNITS-1:0]      unit_clock_enable,
  output logic                             pci_clock_enable,
  output logic [1:0]                       memory_clock_enable,
  output logic                             memory_clock_enable_oe_n,
  output logic                             ethernet1_gigabit_tx_clock,
  output logic                             ethernet1_gigabit_tx_clock_oe_n,
  output logic                             txd3_low_seen
);
  import scr_pkg::*;

  typedef enum logic [1:0] {SCR_WAIT, SCR_RUN} scr_state_e;

  function automatic logic [5:0] scr_factor_mult(input logic [3:0] code);
    scr_factor_mult = (code == FACTOR_X16_CODE) ? FACTOR_X16 : {2'h0, code};
  endfunction

  function automatic logic [1:0] scr_half_m1(input logic [3:0] sel);
    case (sel)
      LBDIV_4: scr_half_m1 = 2'h1;
      LBDIV_8: scr_half_m1 = 2'h3;
      default: scr_half_m1 = 2'h0;
    endcase
  endfunction

  logic [STRAP_W-1:0]   strap_m_q;
  logic [STRAP_W-1:0]   strap_s_q;
  scr_state_e           state_q;
  scr_state_e           state_d;
  logic [1:0]           cap_cnt_q;
  logic [RCW_W-1:0]     cfgw_q;
  logic                 primary_clock_input_div_q;
  logic                 host_q;
  logic                 csb_ph_q;
  logic                 mbclk_q;
  logic                 mtick_q;
  logic [1:0]           lb_cnt_q;
  logic                 lclk_q;
  logic                 half_ph_q;
  logic [1:0]           third_cnt_q;
  logic [N_UNITS-1:0]   unit_en_q;
  logic                 pci_en_q;
  logic                 gtx_q;
  logic [3:0]           lbdiv_q;
  logic [7:0]           uclk_q;
  logic                 pci_sel_q;
  logic                 rvalid_q;
  logic [31:0]          rdata_q;
  logic                 txd3_low_q;

  wire                  running    = (state_q == SCR_RUN);
  wire [3:0]            factor_code = cfgw_q[FACTOR_LSB +: FACTOR_W];
  wire [5:0]            factor_mult = scr_factor_mult(factor_code);
  wire                  ddr_mode   = cfgw_q[MEM_MODE_BIT];
  wire                  lbiu_mode  = cfgw_q[LB_MODE_BIT];
  wire                  csb_tick   = running & csb_ph_q;
  wire                  ddr_tick   = running & (ddr_mode | csb_ph_q);
  wire                  lbiu_tick  = running & (lbiu_mode | csb_ph_q);
  wire                  half_tick  = csb_tick & half_ph_q;
  wire                  third_tick = csb_tick & (third_cnt_q == 2'h0);
  wire [1:0]            half_m1    = scr_half_m1(lbdiv_q);
  wire                  lb_wrap    = (lb_cnt_q >= half_m1);
  wire                  wr_lbcc    = avs_write & (avs_address == LBCC_OFS);
  wire                  wr_uclk    = avs_write & (avs_address == UCLK_OFS);
  wire                  lbdiv_ok   = (avs_writedata[3:0] == LBDIV_2) |
                                     (avs_writedata[3:0] == LBDIV_4) |
                                     (avs_writedata[3:0] == LBDIV_8);
  wire [31:0]           ratio_word = {12'h000, 1'b0, core_pll_ratio, csb_primary_ratio,
                                      csb_input_ratio};
  wire [31:0]           rd_mux     = (avs_address == LBCC_OFS)  ? {28'h0, lbdiv_q} :
                                     (avs_address == UCLK_OFS)  ? {23'h0, pci_sel_q, uclk_q} :
                                     (avs_address == CFGW_OFS)  ? cfgw_q :
                                     (avs_address == RATIO_OFS) ? ratio_word : 32'h0;

  // Straps from pins, two flops before use
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_m_q <= '0;
      strap_s_q <= '0;
    end else begin
      strap_m_q <= {ethernet1_tx_data_bit3, pci_host_mode, input_divide_config_bit,
                    reset_config_word_low};
      strap_s_q <= strap_m_q;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      SCR_WAIT: if (cap_cnt_q == 2'h0) state_d = SCR_RUN;
      SCR_RUN:  state_d = SCR_RUN;
      default:  state_d = SCR_WAIT;
    endcase
  end

  // Capture once after release; never reloaded while running
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q     <= SCR_WAIT;
      cap_cnt_q   <= CAP_WAIT;
      cfgw_q      <= '0;
      primary_clock_input_div_q <= 1'b0;
      host_q      <= 1'b0;
    end else begin
      state_q <= state_d;
      if (cap_cnt_q != 2'h0) begin
        cap_cnt_q <= cap_cnt_q - 2'h1;
      end
      if (state_q == SCR_WAIT && cap_cnt_q == 2'h0) begin // [RULE4] [RULE13]
        cfgw_q      <= strap_s_q[RCW_W-1:0];
        primary_clock_input_div_q <= strap_s_q[RCW_W];
        host_q      <= strap_s_q[RCW_W+1];
      end
    end
  end

  // Bit 3 must stay high while in reset; a low seen at capture is flagged
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txd3_low_q <= 1'b0;
    end else if (state_q == SCR_WAIT && cap_cnt_q == 2'h0) begin
      txd3_low_q <= ~strap_s_q[RCW_W+2]; // [RULE11]
    end
  end

  // Ratio reporting
  always_comb begin
    csb_input_ratio   = primary_clock_input_div_q ? 6'(factor_mult << 1) : factor_mult; // [RULE1] [RULE12]
    csb_primary_ratio = host_q ? factor_mult : csb_input_ratio;          // [RULE2]
  end
  assign core_pll_ratio  = cfgw_q[CORE_LSB +: CORE_W];                 // [RULE3] [RULE4]
  assign config_valid    = running;
  assign config_reserved = running & (factor_code == FACTOR_RSVD);     // [RULE12]

  // sys_clk stands for twice the csb rate; csb ticks every other cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      csb_ph_q <= 1'b0;
      mbclk_q  <= 1'b0;
      mtick_q  <= 1'b0;
    end else begin
      csb_ph_q <= running & ~csb_ph_q;
      mtick_q  <= ddr_tick;                                            // [RULE5] [RULE6]
      if (ddr_tick) begin
        mbclk_q <= ~mbclk_q;                                           // [RULE6]
      end
    end
  end
  assign memory_bus_clock_out_p = mbclk_q;
  assign memory_bus_clock_out_n = ~mbclk_q;
  assign memory_data_tick       = mtick_q;

  // Local bus divider; a wrap on >= survives a divider change mid-count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lb_cnt_q <= 2'h0;
      lclk_q   <= 1'b0;
    end else if (lbiu_tick) begin                                      // [RULE8]
      if (lb_wrap) begin
        lb_cnt_q <= 2'h0;
        lclk_q   <= ~lclk_q;                                           // [RULE7] [RULE8]
      end else begin
        lb_cnt_q <= lb_cnt_q + 2'h1;
      end
    end
  end
  assign local_sync_clock_out    = lclk_q;
  assign local_bus_clock_outputs = {3{lclk_q}};                        // [RULE7]

  // Shared half and third rate phases for the unit enables
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      half_ph_q   <= 1'b0;
      third_cnt_q <= 2'h0;
    end else if (csb_tick) begin
      half_ph_q   <= ~half_ph_q;
      third_cnt_q <= (third_cnt_q == 2'h2) ? 2'h0 : third_cnt_q + 2'h1;
    end
  end

  // Enables are pulses, not gated clocks; units qualify their own flops
  genvar gi;
  generate
    for (gi = 0; gi < N_UNITS; gi++) begin : g_unit
      wire [1:0] sel = uclk_q[2*gi +: 2];
      wire       tick = (sel == UCLK_FULL)  ? csb_tick :
                        (sel == UCLK_HALF)  ? half_tick :
                        (sel == UCLK_THIRD) ? third_tick : 1'b0;
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          unit_en_q[gi] <= 1'b0;
        end else begin
          unit_en_q[gi] <= tick;                                       // [RULE9]
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pci_en_q <= 1'b0;
    end else begin
      pci_en_q <= pci_sel_q & csb_tick;                                // [RULE9]
    end
  end
  assign unit_clock_enable = unit_en_q;
  assign pci_clock_enable  = pci_en_q;

  // Pins kept out of high impedance, even in reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      gtx_q <= 1'b0;
    end else begin
      gtx_q <= ~gtx_q;
    end
  end
  assign ethernet1_gigabit_tx_clock      = gtx_q;
  assign ethernet1_gigabit_tx_clock_oe_n = 1'b0;                       // [RULE10]
  assign memory_clock_enable             = {2{running}};
  assign memory_clock_enable_oe_n        = 1'b0;                       // [RULE10]
  assign txd3_low_seen                   = txd3_low_q;

  // Registers: writes take effect at once, reads have one wait state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lbdiv_q   <= LBDIV_RST;
      uclk_q    <= UCLK_RST;
      pci_sel_q <= PCI_RST;
    end else begin
      if (wr_lbcc && lbdiv_ok) begin
        lbdiv_q <= avs_writedata[3:0];                                 // [RULE8]
      end
      if (wr_uclk) begin
        uclk_q    <= avs_writedata[7:0];                               // [RULE9]
        pci_sel_q <= avs_writedata[PCI_BIT];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
    end else begin
      rvalid_q <= avs_read & ~rvalid_q;
      if (avs_read && !rvalid_q) begin
        rdata_q <= rd_mux;
      end
    end
  end
  assign avs_waitrequest = avs_read & ~rvalid_q;
  assign avs_readdata    = rdata_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Checks beside the logic they guard; reset guards keep $past clear of reset values
  cfg_hold_a: assert property (running && $past(running) |-> $stable(cfgw_q)) // [RULE13]
    else $error("configuration changed while running");
  factor_sixteen_a: assert property (running && factor_code == 4'h0 && !primary_clock_input_div_q // [RULE12]
    |-> csb_input_ratio == 6'h10)
    else $error("code zero not sixteen");
  csb_double_a: assert property (running && primary_clock_input_div_q && factor_code == 4'h5 // [RULE1]
    |-> csb_input_ratio == 6'h0A)
    else $error("input divide did not double ratio");
  host_term_a: assert property (running && host_q |-> csb_primary_ratio == factor_mult) // [RULE2]
    else $error("host ratio wrong");
  agent_term_a: assert property (running && !host_q |-> csb_primary_ratio == csb_input_ratio) // [RULE2]
    else $error("agent ratio wrong");
  csb_rate_a: assert property (running && $past(running) |-> csb_ph_q != $past(csb_ph_q)) // [RULE5]
    else $error("csb tick not every other cycle");
  mem_div_a: assert property (running && ddr_mode |=> mbclk_q != $past(mbclk_q)) // [RULE5]
    else $error("memory clock not at full ddr rate");
  mem_slow_a: assert property (running && !ddr_mode && $past(running) && mbclk_q != $past(mbclk_q)
    |=> mbclk_q == $past(mbclk_q)) // [RULE6]
    else $error("memory clock toggled twice at 1x mode");
  lb_div2_a: assert property (running && $past(running) && lbiu_mode && $past(lbdiv_q) == 4'h2
    |-> lclk_q != $past(lclk_q)) // [RULE8]
    else $error("divide by two local clock not toggling");
  pci_full_a: assert property (pci_sel_q && $past(pci_sel_q) && $past(csb_tick) |-> pci_en_q) // [RULE9]
    else $error("pci enable missed a csb tick");
  txd3_flag_a: assert property ($rose(running)
    |-> txd3_low_q == !$past(strap_s_q[RCW_W+2])) // [RULE11]
    else $error("bit 3 level not flagged at capture");
  gtx_toggle_a: assert property (!$past(rst) |-> gtx_q != $past(gtx_q)) // [RULE10]
    else $error("gigabit tx clock not toggling");
  lb_div8_a: assert property (running && lbiu_mode && lbdiv_q == 4'h8 && $rose(lclk_q)
    && $past(lbdiv_q) == 4'h8 |-> ##1 (lclk_q [*3])) // [RULE8]
    else $error("divide by eight half period short");
  unit_off_a: assert property (uclk_q[1:0] == 2'h0 |=> !unit_en_q[0]) // [RULE9]
    else $error("unit enabled while off");
  pci_off_a: assert property (!pci_sel_q |=> !pci_en_q) // [RULE9]
    else $error("pci enabled while off");
  read_wait_a: assert property (avs_read && !avs_waitrequest |-> $past(avs_read)) // [RULE9]
    else $error("read answered without wait state");
  reset_drive_a: assert property (disable iff (1'b0) rst
    |-> !memory_clock_enable_oe_n && !ethernet1_gigabit_tx_clock_oe_n) // [RULE10]
    else $error("pin not driven in reset");

  run_c: cover property ($rose(running));
  read_c: cover property (avs_read && !avs_waitrequest && avs_address == 4'hC);
  third_c: cover property (uclk_q[1:0] == 2'h3 && unit_en_q[0]);
  mem_fast_c: cover property (running && ddr_mode);
  div8_c: cover property (running && lbdiv_q == 4'h8 && $rose(lclk_q));
endmodule

/* File: verif/scr_board_model.sv */
`timescale 1ns/10ps
// Board strapping and pin levels seen by the block
module scr_board_model (
  input  wire logic [31:0] word_req,
  input  wire logic        div_req,
  input  wire logic        host_req,
  output logic      [31:0] reset_config_word_low,
  output logic             input_divide_config_bit,
  output logic             pci_host_mode,
  output logic             ethernet1_tx_data_bit3
);
  assign reset_config_word_low   = word_req;
  assign input_divide_config_bit = div_req;
  assign pci_host_mode           = host_req;
  // Pulled up at all times, never pulled low
  assign ethernet1_tx_data_bit3  = 1'b1;
endmodule

/* File: verif/tb.sv */
`timescale 1ns/10ps
module tb;
  import scr_pkg::*;
  logic        sys_clk, rst = 1'b1, div_req = 1'b0, host_req = 1'b0;
  logic [31:0] word_req = 32'h0, reset_config_word_low, avs_writedata = 32'h0, avs_readdata;
  logic        input_divide_config_bit, pci_host_mode, ethernet1_tx_data_bit3;
  logic [3:0]  avs_address = 4'h0, unit_clock_enable;
  logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, config_valid;
  logic        config_reserved, memory_bus_clock_out_p, memory_bus_clock_out_n;
  logic [5:0]  csb_input_ratio, csb_primary_ratio;
  logic [6:0]  core_pll_ratio;
  logic        memory_data_tick, local_sync_clock_out, pci_clock_enable, txd3_low_seen;
  logic [2:0]  local_bus_clock_outputs;
  logic [1:0]  memory_clock_enable;
  logic        memory_clock_enable_oe_n, ethernet1_gigabit_tx_clock;
  logic        ethernet1_gigabit_tx_clock_oe_n;
  int          miscompares = 0, tests_run = 0, cyc = 0;
  int          n_t, n_m, n_l, n_p, n_g, n_bad, n_u[4];

  scr_board_model board (.word_req, .div_req, .host_req, .reset_config_word_low,
    .input_divide_config_bit, .pci_host_mode, .ethernet1_tx_data_bit3);
  scr_clock_ratio_ctrl dut (.sys_clk, .rst, .reset_config_word_low,
    .input_divide_config_bit, .pci_host_mode, .ethernet1_tx_data_bit3, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .config_valid, .config_reserved, .csb_input_ratio, .csb_primary_ratio,
    .core_pll_ratio, .memory_bus_clock_out_p, .memory_bus_clock_out_n,
    .memory_data_tick, .local_sync_clock_out, .local_bus_clock_outputs,
    .unit_clock_enable, .pci_clock_enable, .memory_clock_enable,
    .memory_clock_enable_oe_n, .ethernet1_gigabit_tx_clock,
    .ethernet1_gigabit_tx_clock_oe_n, .txd3_low_seen);

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic stop_test;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Far above the roughly one thousand cycles the scenarios need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic reset_dut(input logic [31:0] w, input logic d, input logic h);
    word_req <= w;
    div_req <= d;
    host_req <= h;
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("memory_clock_enable oe_n in reset", 0, memory_clock_enable_oe_n);
    chk("gtx oe_n in reset", 0, ethernet1_gigabit_tx_clock_oe_n);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk("config valid", 1, config_valid);
  endtask

  // Edge and pulse counts over a window; pre-edge values on each edge
  task automatic measure(input int n);
    logic p_m, p_l, p_g;
    n_t = 0; n_m = 0; n_l = 0; n_p = 0; n_g = 0; n_bad = 0; n_u = '{default: 0};
    p_m = memory_bus_clock_out_p;
    p_l = local_sync_clock_out;
    p_g = ethernet1_gigabit_tx_clock;
    repeat (n) begin
      @(posedge sys_clk);
      n_t += int'(memory_data_tick === 1'b1);
      n_m += int'(memory_bus_clock_out_p !== p_m);
      n_l += int'(local_sync_clock_out !== p_l);
      n_p += int'(pci_clock_enable === 1'b1);
      n_g += int'(ethernet1_gigabit_tx_clock !== p_g);
      p_g = ethernet1_gigabit_tx_clock;
      n_bad += int'(memory_bus_clock_out_n !== ~memory_bus_clock_out_p);
      n_bad += int'(local_bus_clock_outputs !== {3{local_sync_clock_out}});
      foreach (n_u[i]) n_u[i] += int'(unit_clock_enable[i] === 1'b1);
      p_m = memory_bus_clock_out_p;
      p_l = local_sync_clock_out;
    end
  endtask

  task automatic t_ratio;
    logic [31:0] d, w;
    int f, ci;
    for (int k = 0; k < 16; k++) begin
      f = (k == 0) ? 16 : k;
      ci = f * (1 + k[0]);
      w = {4'h0, k[3:0], 1'b0, 7'(k + 32), 16'h0};
      reset_dut(w, k[0], k[1]);
      chk("reserved flag", k == 1, config_reserved);
      if (k != 1) begin
        chk("csb input ratio", ci, csb_input_ratio);
        chk("csb primary ratio", k[1] ? f : ci, csb_primary_ratio);
        chk("core ratio", k + 32, core_pll_ratio);
      end
      rd(CFGW_OFS, d);
      chk("captured word", w, d);
      chk("memory_clock_enable", 3, memory_clock_enable);
      chk("txd3 flag", 0, txd3_low_seen);
    end
    rd(RATIO_OFS, d);
    chk("ratio reg", {13'h0, 7'd47, 6'd15, 6'd30}, d);
    word_req <= 32'h0200_0000;
    div_req <= 1'b0;
    wr(CFGW_OFS, 32'h0);
    repeat (8) @(posedge sys_clk);
    chk("held input ratio", 30, csb_input_ratio);
    rd(CFGW_OFS, d);
    chk("held word", w, d);
  endtask

  task automatic t_clk(input logic m);
    logic [31:0] d;
    int dv[3] = '{2, 4, 8};
    reset_dut({m, m, 6'h04, 24'h0}, 1'b0, 1'b0);
    measure(32);
    chk("data ticks", m ? 32 : 16, n_t);
    chk("memory clock edges", m ? 32 : 16, n_m);
    chk("memory clock pair", 0, n_bad);
    chk("gtx edges", 32, n_g);
    foreach (dv[i]) begin
      wr(LBCC_OFS, dv[i]);
      wr(LBCC_OFS, 32'h3);
      rd(LBCC_OFS, d);
      chk("divider select", dv[i], d);
      repeat (32) @(posedge sys_clk);
      measure(64);
      chk("local edges", 128 / ((2 - m) * dv[i]), n_l);
      chk("local outputs", 0, n_bad);
    end
  endtask

  task automatic t_units;
    logic [31:0] d;
    int ex[4] = '{0, 12, 6, 4};
    reset_dut(32'h0400_0000, 1'b0, 1'b1);
    rd(UCLK_OFS, d);
    chk("unit sel reset", {23'h0, PCI_RST, UCLK_RST}, d);
    measure(24);
    foreach (n_u[i]) chk("unit default", 4, n_u[i]);
    chk("pci default", 12, n_p);
    wr(UCLK_OFS, 32'h0E4);
    repeat (12) @(posedge sys_clk);
    measure(24);
    foreach (n_u[i]) chk("unit rate", ex[i], n_u[i]);
    chk("pci off", 0, n_p);
    rd(4'h1, d);
    chk("unmapped read", 0, d);
  endtask

  initial begin
    t_ratio();
    t_clk(1'b0);
    t_clk(1'b1);
    t_units();
    stop_test();
  end
endmodule
